// file: rtl/ind_addr_pkg.sv
// Purpose: Shared types and constants for the indirect address generator
// Assumes: 16-bit byte-addressed data space, core register file outside this block
// Notes: Overview of operation is listed below
//
// Overview of operation
// RULE1: No-modify mode uses the base pointer as the address and writes nothing back.
// RULE2: Pre-increment adds 1 (byte) or 2 (word) to the pointer and uses the new value.
// RULE3: Pre-decrement subtracts 1 (byte) or 2 (word) and uses the new value.
// RULE4: Post-increment uses the old pointer and then adds 1 (byte) or 2 (word) to it.
// RULE5: Post-decrement uses the old pointer and then subtracts 1 (byte) or 2 (word).
// RULE6: The pointer update is produced together with the address, with no extra cycle.
// RULE7: Every address is a byte address, so word updates step by 2 to the next word.
// RULE8: Register-offset mode adds base and offset registers and modifies neither.
// RULE9: The offset register is added unscaled even for word operations.
// RULE10: Literal-offset moves add a sign-extended 10-bit literal to the base register.
// RULE11: Register offset is only for moves and accumulator DSP instructions, literal only for moves.
// RULE12: A multiply-accumulate instruction yields separate X and Y prefetch addresses.
// RULE13: Prefetch pointers allow no-modify and post-increment or decrement by 2, 4 or 6.
// RULE14: Prefetches are word only, so no odd update step exists.
// RULE15: Prefetch register offset uses the second X or Y pointer plus the shared offset.
// RULE16: Only the two X pointers serve X prefetches and only the two Y pointers serve Y.
// RULE17: All sums and updates wrap within 16 bits.

package ind_addr_pkg;

    localparam int ADDR_W = 16;
    localparam int LIT_W = 10;
    localparam int IDX_W = 4;

    localparam logic [ADDR_W-1:0] BYTE_STEP = 16'h0001;
    localparam logic [ADDR_W-1:0] WORD_STEP = 16'h0002;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

    localparam logic [1:0] MAC_STEP_2 = 2'h1;
    localparam logic [1:0] MAC_STEP_4 = 2'h2;
    localparam logic [1:0] MAC_STEP_6 = 2'h3;

    localparam logic [IDX_W-1:0] X_POINTER_A_IDX = 4'h8;
    localparam logic [IDX_W-1:0] X_POINTER_B_IDX = 4'h9;
    localparam logic [IDX_W-1:0] Y_POINTER_A_IDX = 4'hA;
    localparam logic [IDX_W-1:0] Y_POINTER_B_IDX = 4'hB;
    localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;

    typedef enum logic [6:0] {
        MODE_NO_MOD     = 7'h01,
        MODE_PRE_INC    = 7'h02,
        MODE_PRE_DEC    = 7'h04,
        MODE_POST_INC   = 7'h08,
        MODE_POST_DEC   = 7'h10,
        MODE_REG_OFFSET = 7'h20,
        MODE_LIT_OFFSET = 7'h40
    } mode_t;

    typedef enum logic [2:0] {
        KIND_MOVE    = 3'h1,
        KIND_ACC_DSP = 3'h2,
        KIND_OTHER   = 3'h4
    } instr_kind_t;

    typedef enum logic [3:0] {
        MAC_NO_MOD   = 4'h1,
        MAC_POST_INC = 4'h2,
        MAC_POST_DEC = 4'h4,
        MAC_REG_OFF  = 4'h8
    } mac_mode_t;

    typedef struct packed {
        logic valid;
        mode_t mode;
        logic byte_op;
        instr_kind_t kind;
        logic [ADDR_W-1:0] base_pointer_reg;
        logic [ADDR_W-1:0] offset_reg;
        logic [LIT_W-1:0] literal;
    } gen_req_t;

    typedef struct packed {
        mac_mode_t mode;
        logic [1:0] step;
        logic [IDX_W-1:0] idx;
    } mac_side_req_t;

    typedef struct packed {
        logic valid;
        mac_side_req_t x;
        mac_side_req_t y;
    } mac_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] x_pointer_a;
        logic [ADDR_W-1:0] x_pointer_b;
        logic [ADDR_W-1:0] y_pointer_a;
        logic [ADDR_W-1:0] y_pointer_b;
        logic [ADDR_W-1:0] shared_prefetch_offset_reg;
    } mac_regs_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [ADDR_W-1:0] effective_address;
        logic wr_en;
        logic [ADDR_W-1:0] wr_value;
    } gen_out_t;

    typedef struct packed {
        logic illegal;
        logic [ADDR_W-1:0] effective_address;
        logic wr_en;
        logic [IDX_W-1:0] wr_idx;
        logic [ADDR_W-1:0] wr_value;
    } side_out_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        side_out_t x;
        side_out_t y;
    } mac_out_t;

    typedef struct packed {
        gen_out_t gen;
        mac_out_t mac;
    } state_t;

endpackage

// file: rtl/indirect_address_generator.sv
// Purpose: Effective address and pointer update generation for indirect data accesses
// Assumes: Core presents operands in the cycle of the request and writes back the update
// Notes: Results register one edge after the request; one request per cycle per port
`timescale 1ns/100ps
`default_nettype none

module indirect_address_generator (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // General indirect request
    input wire ind_addr_pkg::gen_req_t gen_req_in,
    // Multiply-accumulate prefetch request and pointer contents
    input wire ind_addr_pkg::mac_req_t mac_req_in,
    input wire ind_addr_pkg::mac_regs_t mac_regs_in,
    // Results
    output var ind_addr_pkg::gen_out_t gen_out,
    output var ind_addr_pkg::mac_out_t mac_out
);
    import ind_addr_pkg::*;

    state_t st;
    state_t next_st;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [ADDR_W-1:0] mac_step(input logic [1:0] code);
        logic [ADDR_W-1:0] v;
        v = ADDR_RESET;
        case (code)
            MAC_STEP_2: v = 16'h0002;
            MAC_STEP_4: v = 16'h0004;
            MAC_STEP_6: v = 16'h0006;
            default: v = ADDR_RESET;
        endcase
        return v;
    endfunction

    // One prefetch side; X and Y differ only in their pointer pair
    function automatic side_out_t mac_side(
        input mac_side_req_t rq,
        input logic [IDX_W-1:0] idx_a,
        input logic [IDX_W-1:0] idx_b,
        input logic [ADDR_W-1:0] val_a,
        input logic [ADDR_W-1:0] val_b,
        input logic [ADDR_W-1:0] offs
    );
        side_out_t r;
        logic [ADDR_W-1:0] ptr;
        logic idx_ok;
        r = '0;
        idx_ok = (rq.idx == idx_a) || (rq.idx == idx_b); // see RULE16
        ptr = (rq.idx == idx_b) ? val_b : val_a;
        case (rq.mode)
            MAC_NO_MOD: begin
                r.illegal = !idx_ok;
                r.effective_address = ptr; // see RULE13
            end
            MAC_POST_INC: begin
                r.illegal = !idx_ok || (rq.step == 2'h0); // see RULE14
                r.effective_address = ptr;
                r.wr_en = 1'b1;
                r.wr_idx = rq.idx;
                r.wr_value = ptr + mac_step(rq.step); // see RULE13
            end
            MAC_POST_DEC: begin
                r.illegal = !idx_ok || (rq.step == 2'h0); // see RULE14
                r.effective_address = ptr;
                r.wr_en = 1'b1;
                r.wr_idx = rq.idx;
                r.wr_value = ptr - mac_step(rq.step); // see RULE13
            end
            MAC_REG_OFF: begin
                r.effective_address = val_b + offs; // see RULE15
            end
            default: begin
                r.illegal = 1'b1;
            end
        endcase
        if (r.illegal) begin
            r = '0;
            r.illegal = 1'b1;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [ADDR_W-1:0] step;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] lit_ext;
        next_st = st;
        step = gen_req_in.byte_op ? BYTE_STEP : WORD_STEP; // see RULE7
        base = gen_req_in.base_pointer_reg;
        lit_ext = {{(ADDR_W-LIT_W){gen_req_in.literal[LIT_W-1]}}, gen_req_in.literal};

        next_st.gen = '0;
        next_st.gen.valid = gen_req_in.valid;
        if (gen_req_in.valid) begin
            case (gen_req_in.mode)
                MODE_NO_MOD: begin
                    next_st.gen.effective_address = base; // see RULE1
                end
                MODE_PRE_INC: begin
                    next_st.gen.effective_address = base + step; // see RULE2
                    next_st.gen.wr_en = 1'b1; // see RULE6
                    next_st.gen.wr_value = base + step; // see RULE17
                end
                MODE_PRE_DEC: begin
                    next_st.gen.effective_address = base - step; // see RULE3
                    next_st.gen.wr_en = 1'b1;
                    next_st.gen.wr_value = base - step;
                end
                MODE_POST_INC: begin
                    next_st.gen.effective_address = base; // see RULE4
                    next_st.gen.wr_en = 1'b1;
                    next_st.gen.wr_value = base + step;
                end
                MODE_POST_DEC: begin
                    next_st.gen.effective_address = base; // see RULE5
                    next_st.gen.wr_en = 1'b1;
                    next_st.gen.wr_value = base - step;
                end
                MODE_REG_OFFSET: begin
                    if (gen_req_in.kind == KIND_OTHER) begin
                        next_st.gen.illegal = 1'b1; // see RULE11
                    end else begin
                        // Unscaled sum, neither register written
                        next_st.gen.effective_address = base + gen_req_in.offset_reg; // see RULE8, RULE9
                    end
                end
                MODE_LIT_OFFSET: begin
                    if (gen_req_in.kind != KIND_MOVE) begin
                        next_st.gen.illegal = 1'b1; // see RULE11
                    end else begin
                        next_st.gen.effective_address = base + lit_ext; // see RULE10
                    end
                end
                default: begin
                    next_st.gen.illegal = 1'b1;
                end
            endcase
        end

        next_st.mac = '0;
        next_st.mac.valid = mac_req_in.valid;
        if (mac_req_in.valid) begin
            // Two independent addresses per instruction
            next_st.mac.x = mac_side(mac_req_in.x, X_POINTER_A_IDX, X_POINTER_B_IDX,
                mac_regs_in.x_pointer_a, mac_regs_in.x_pointer_b,
                mac_regs_in.shared_prefetch_offset_reg); // see RULE12
            next_st.mac.y = mac_side(mac_req_in.y, Y_POINTER_A_IDX, Y_POINTER_B_IDX,
                mac_regs_in.y_pointer_a, mac_regs_in.y_pointer_b,
                mac_regs_in.shared_prefetch_offset_reg); // see RULE12
            next_st.mac.illegal = next_st.mac.x.illegal || next_st.mac.y.illegal;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign gen_out = st.gen;
    assign mac_out = st.mac;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);

    AST_NO_MOD: assert property ( // see RULE1
        gen_req_in.valid && gen_req_in.mode == MODE_NO_MOD |=>
        gen_out.effective_address == $past(gen_req_in.base_pointer_reg) && !gen_out.wr_en)
        else $error("No-modify address or writeback wrong");

    AST_PRE_INC: assert property ( // see RULE2
        gen_req_in.valid && gen_req_in.mode == MODE_PRE_INC |=>
        gen_out.effective_address == gen_out.wr_value && gen_out.wr_en &&
        gen_out.wr_value == $past(gen_req_in.base_pointer_reg) +
        ($past(gen_req_in.byte_op) ? 16'h0001 : 16'h0002))
        else $error("Pre-increment result wrong");

    AST_PRE_DEC: assert property ( // see RULE3
        gen_req_in.valid && gen_req_in.mode == MODE_PRE_DEC |=>
        gen_out.effective_address == gen_out.wr_value &&
        $past(gen_req_in.base_pointer_reg) - gen_out.wr_value ==
        ($past(gen_req_in.byte_op) ? 16'h0001 : 16'h0002))
        else $error("Pre-decrement result wrong");

    AST_POST_INC: assert property ( // see RULE4
        gen_req_in.valid && gen_req_in.mode == MODE_POST_INC |=>
        gen_out.effective_address == $past(gen_req_in.base_pointer_reg) &&
        gen_out.wr_value - gen_out.effective_address ==
        ($past(gen_req_in.byte_op) ? 16'h0001 : 16'h0002))
        else $error("Post-increment result wrong");

    AST_POST_DEC: assert property ( // see RULE5
        gen_req_in.valid && gen_req_in.mode == MODE_POST_DEC && !gen_req_in.byte_op |=>
        gen_out.effective_address - gen_out.wr_value == 16'h0002)
        else $error("Post-decrement word step wrong");

    AST_ONE_CYCLE: assert property ( // see RULE6
        gen_req_in.valid |=> gen_out.valid ##1 gen_out.valid == $past(gen_req_in.valid))
        else $error("Result not produced one cycle after request");

    AST_REG_OFFSET: assert property ( // see RULE8
        gen_req_in.valid && gen_req_in.mode == MODE_REG_OFFSET && gen_req_in.kind != KIND_OTHER
        |=> !gen_out.illegal && !gen_out.wr_en && gen_out.effective_address ==
        $past(gen_req_in.base_pointer_reg) + $past(gen_req_in.offset_reg))
        else $error("Register offset address wrong");

    AST_LIT_OFFSET: assert property ( // see RULE10
        gen_req_in.valid && gen_req_in.mode == MODE_LIT_OFFSET && gen_req_in.kind == KIND_MOVE
        |=> gen_out.effective_address == $past(gen_req_in.base_pointer_reg) +
        {{6{$past(gen_req_in.literal[9])}}, $past(gen_req_in.literal)})
        else $error("Literal offset address wrong");

    AST_OFFSET_KIND: assert property ( // see RULE11
        gen_req_in.valid && gen_req_in.kind == KIND_OTHER &&
        (gen_req_in.mode == MODE_REG_OFFSET || gen_req_in.mode == MODE_LIT_OFFSET)
        |=> gen_out.illegal && !gen_out.wr_en)
        else $error("Offset mode accepted for wrong instruction");

    AST_MAC_X_STEP: assert property ( // see RULE13
        mac_req_in.valid && mac_req_in.x.mode == MAC_POST_INC &&
        mac_req_in.x.idx == X_POINTER_A_IDX && mac_req_in.x.step == MAC_STEP_6
        |=> mac_out.x.wr_en && mac_out.x.wr_value == $past(mac_regs_in.x_pointer_a) + 16'h0006)
        else $error("X prefetch step of 6 wrong");

    AST_MAC_Y_OFF: assert property ( // see RULE15
        mac_req_in.valid && mac_req_in.y.mode == MAC_REG_OFF |=>
        mac_out.y.effective_address == $past(mac_regs_in.y_pointer_b) +
        $past(mac_regs_in.shared_prefetch_offset_reg) && !mac_out.y.wr_en)
        else $error("Y prefetch register offset wrong");

    AST_MAC_IDX: assert property ( // see RULE16
        mac_req_in.valid && mac_req_in.x.mode != MAC_REG_OFF &&
        mac_req_in.x.idx != X_POINTER_A_IDX && mac_req_in.x.idx != X_POINTER_B_IDX
        |=> mac_out.x.illegal && mac_out.illegal && !mac_out.x.wr_en)
        else $error("Non-X pointer accepted for X prefetch");

    AST_MAC_EVEN: assert property ( // see RULE14
        mac_out.valid && !mac_out.illegal |->
        !mac_out.x.wr_value[0] || !mac_out.x.wr_en || $past(mac_regs_in.x_pointer_a[0]) ||
        $past(mac_regs_in.x_pointer_b[0]))
        else $error("Odd prefetch update step");

    AST_IDLE_GEN: assert property ( // see RULE6
        !gen_req_in.valid |=>
        !gen_out.valid && !gen_out.wr_en && !gen_out.illegal)
        else $error("General result without request");

    AST_POST_DEC_BYTE: assert property ( // see RULE5
        gen_req_in.valid && gen_req_in.mode == MODE_POST_DEC && gen_req_in.byte_op |=>
        gen_out.wr_en && gen_out.effective_address == $past(gen_req_in.base_pointer_reg) &&
        gen_out.effective_address - gen_out.wr_value == 16'h0001)
        else $error("Post-decrement byte step wrong");

    AST_WORD_SCALE: assert property ( // see RULE7
        gen_req_in.valid && !gen_req_in.byte_op &&
        (gen_req_in.mode == MODE_PRE_INC || gen_req_in.mode == MODE_POST_INC) |=>
        gen_out.wr_en && gen_out.wr_value == $past(gen_req_in.base_pointer_reg) + 16'h0002)
        else $error("Word update not scaled by two");

    AST_WRAP: assert property ( // see RULE17
        gen_req_in.valid && gen_req_in.mode == MODE_PRE_INC && !gen_req_in.byte_op &&
        gen_req_in.base_pointer_reg == 16'hFFFF |=> gen_out.effective_address == 16'h0001)
        else $error("Address did not wrap within 16 bits");

    AST_ILLEGAL_ZERO: assert property ( // see RULE11
        gen_out.illegal |->
        gen_out.effective_address == 16'h0000 && !gen_out.wr_en && gen_out.wr_value == 16'h0000)
        else $error("Refused request left fields set");

    AST_MAC_ONE_CYCLE: assert property ( // see RULE12
        mac_req_in.valid |=> mac_out.valid)
        else $error("Prefetch result missing");

    AST_MAC_IDLE: assert property ( // see RULE12
        !mac_req_in.valid |=> !mac_out.valid && !mac_out.x.wr_en && !mac_out.y.wr_en)
        else $error("Prefetch writeback without request");

    AST_MAC_Y_STEP: assert property ( // see RULE13
        mac_req_in.valid && mac_req_in.y.mode == MAC_POST_DEC &&
        mac_req_in.y.idx == Y_POINTER_B_IDX && mac_req_in.y.step == MAC_STEP_2 |=>
        mac_out.y.wr_en && mac_out.y.wr_idx == Y_POINTER_B_IDX &&
        mac_out.y.wr_value == $past(mac_regs_in.y_pointer_b) - 16'h0002)
        else $error("Y prefetch step of 2 wrong");

    AST_MAC_X_DEC: assert property ( // see RULE13
        mac_req_in.valid && mac_req_in.x.mode == MAC_POST_DEC &&
        mac_req_in.x.idx == X_POINTER_B_IDX && mac_req_in.x.step == MAC_STEP_2 |=>
        mac_out.x.effective_address == $past(mac_regs_in.x_pointer_b) &&
        mac_out.x.wr_value == $past(mac_regs_in.x_pointer_b) - 16'h0002)
        else $error("X prefetch post-decrement wrong");

    AST_MAC_NO_MOD: assert property ( // see RULE13
        mac_req_in.valid && mac_req_in.y.mode == MAC_NO_MOD &&
        mac_req_in.y.idx == Y_POINTER_A_IDX |=>
        mac_out.y.effective_address == $past(mac_regs_in.y_pointer_a) && !mac_out.y.wr_en)
        else $error("Y prefetch no-modify wrong");

    AST_MAC_X_OFF: assert property ( // see RULE15
        mac_req_in.valid && mac_req_in.x.mode == MAC_REG_OFF |=>
        mac_out.x.effective_address == $past(mac_regs_in.x_pointer_b) +
        $past(mac_regs_in.shared_prefetch_offset_reg) && !mac_out.x.wr_en)
        else $error("X prefetch register offset wrong");

    AST_MAC_Y_IDX: assert property ( // see RULE16
        mac_req_in.valid && mac_req_in.y.mode != MAC_REG_OFF &&
        mac_req_in.y.idx != Y_POINTER_A_IDX && mac_req_in.y.idx != Y_POINTER_B_IDX
        |=> mac_out.y.illegal && mac_out.illegal && !mac_out.y.wr_en)
        else $error("Non-Y pointer accepted for Y prefetch");

    AST_MAC_STEP_ZERO: assert property ( // see RULE14
        mac_req_in.valid && mac_req_in.y.step == 2'h0 &&
        (mac_req_in.y.mode == MAC_POST_INC || mac_req_in.y.mode == MAC_POST_DEC)
        |=> mac_out.y.illegal && !mac_out.y.wr_en)
        else $error("Prefetch update without step size");

    COV_POST_INC_BYTE: cover property (
        gen_req_in.valid && gen_req_in.mode == MODE_POST_INC && gen_req_in.byte_op);
    COV_BACK_TO_BACK: cover property (
        gen_req_in.valid && gen_req_in.mode == MODE_PRE_DEC ##1
        gen_req_in.valid && gen_req_in.mode == MODE_PRE_DEC);
    COV_LIT_NEG: cover property (
        gen_req_in.valid && gen_req_in.mode == MODE_LIT_OFFSET && gen_req_in.literal[9]);
    COV_MAC_BOTH: cover property (
        mac_req_in.valid && mac_req_in.x.mode == MAC_POST_INC &&
        mac_req_in.y.mode == MAC_POST_DEC ##1 !mac_out.illegal);
    COV_MAC_REG_OFF: cover property (
        mac_req_in.valid && mac_req_in.x.mode == MAC_REG_OFF && mac_req_in.y.mode == MAC_REG_OFF);

endmodule

`default_nettype wire

// file: sim/core_regfile_model.sv
// Purpose: Core register file holding the four prefetch pointers and the shared offset
// Assumes: Prefetch results stand between rising edges; updates land at the falling edge
// Notes: Writing back at the falling edge lets back-to-back prefetches see fresh pointers
`timescale 1ns/100ps
`default_nettype none

module core_regfile_model (
    // Clock
    input wire logic clock_in,
    // Preload from the bench
    input wire logic load_in,
    input wire ind_addr_pkg::mac_regs_t load_val_in,
    // Writeback from the generator
    input wire ind_addr_pkg::mac_out_t wb_in,
    // Register contents
    output var ind_addr_pkg::mac_regs_t regs_out
);
    import ind_addr_pkg::*;

    function automatic mac_regs_t put(mac_regs_t r, side_out_t s);
        if (s.wr_en) begin
            case (s.wr_idx)
                X_POINTER_A_IDX: r.x_pointer_a = s.wr_value;
                X_POINTER_B_IDX: r.x_pointer_b = s.wr_value;
                Y_POINTER_A_IDX: r.y_pointer_a = s.wr_value;
                Y_POINTER_B_IDX: r.y_pointer_b = s.wr_value;
                default: ;
            endcase
        end
        return r;
    endfunction

    initial regs_out = '0;

    always @(negedge clock_in) begin
        if (load_in) begin
            regs_out <= load_val_in;
        end else if (wb_in.valid) begin
            regs_out <= put(put(regs_out, wb_in.x), wb_in.y);
        end
    end
endmodule
`default_nettype wire

// file: sim/indirect_address_generator_tb.sv
// Purpose: Self-checking bench for the indirect address generator
// Assumes: Inputs change at the falling edge; results read at the next falling edge
// Notes: Fields that stand unwritten (no writeback) are not compared
`timescale 1ns/100ps
`default_nettype none

module indirect_address_generator_tb;
    import ind_addr_pkg::*;

    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    gen_req_t gen_req = '0;
    mac_req_t mac_req = '0;
    mac_regs_t regs;
    mac_regs_t sh;
    logic load = 1'b0;
    gen_out_t gen_out;
    mac_out_t mac_out;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    always #10 clock_in = ~clock_in;

    indirect_address_generator i_indirect_address_generator (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .gen_req_in(gen_req),
        .mac_req_in(mac_req), .mac_regs_in(regs), .gen_out(gen_out), .mac_out(mac_out));

    core_regfile_model i_core_regfile_model (
        .clock_in(clock_in), .load_in(load), .load_val_in(sh), .wb_in(mac_out),
        .regs_out(regs));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("[FAIL] %0t run timed out", $time);
            complete_run();
        end
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic gen_op(mode_t m, logic b, instr_kind_t k, logic [15:0] base,
                          logic [15:0] off, logic [9:0] lit, logic ill, logic [15:0] ea,
                          logic wen, logic [15:0] wv);
        gen_req <= '{1'b1, m, b, k, base, off, lit};
        @(negedge clock_in);
        check({gen_out.valid, gen_out.illegal, gen_out.effective_address, gen_out.wr_en,
               wen ? gen_out.wr_value : 16'h0000}, {1'b1, ill, ea, wen, wen ? wv : 16'h0000});
    endtask

    task automatic chk_side(side_out_t s, side_out_t e);
        check({s.illegal, s.effective_address, s.wr_en, e.wr_en ? {s.wr_idx, s.wr_value} : 20'h0},
              {e.illegal, e.effective_address, e.wr_en, e.wr_en ? {e.wr_idx, e.wr_value} : 20'h0});
    endtask

    task automatic mac_op(mac_side_req_t x, mac_side_req_t y, side_out_t ex, side_out_t ey);
        mac_req <= '{1'b1, x, y};
        @(negedge clock_in);
        check({mac_out.valid, mac_out.illegal}, {1'b1, ex.illegal | ey.illegal});
        chk_side(mac_out.x, ex);
        chk_side(mac_out.y, ey);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        check({gen_out, mac_out}, '0);
        sys_rst_in <= 1'b1;
        gen_req <= '{1'b1, MODE_POST_INC, 1'b0, KIND_MOVE, 16'h0890, 16'h0, 10'h0};
        mac_req.valid <= 1'b1;
        @(negedge clock_in);
        check({gen_out, mac_out}, '0);
        sys_rst_in <= 1'b0;
        gen_op(MODE_POST_INC, 1'b0, KIND_MOVE, 16'h0890, 16'h0, 10'h0, 1'b0, 16'h0890, 1'b1, 16'h0892);
        mac_req.valid <= 1'b0;
        gen_req.valid <= 1'b0;
        @(negedge clock_in);
        check({gen_out.valid, mac_out.valid}, 2'b00);
        $display("test reset done");
    endtask

    task automatic test_gen_updates();
        mode_t md[5];
        logic [15:0] st;
        logic [15:0] base;
        logic [15:0] nv;
        md = '{MODE_NO_MOD, MODE_PRE_INC, MODE_PRE_DEC, MODE_POST_INC, MODE_POST_DEC};
        for (int i = 0; i < 5; i++) begin
            for (int b = 0; b < 2; b++) begin
                st = b ? BYTE_STEP : WORD_STEP;
                base = (i == 2 || i == 4) ? 16'h0000 : 16'hFFFF;
                nv = (i == 1 || i == 3) ? base + st : base - st;
                gen_op(md[i], b[0], KIND_OTHER, base, 16'h1234, 10'h000, 1'b0,
                       (i == 1 || i == 2) ? nv : base, i != 0, nv);
            end
        end
        gen_req.valid <= 1'b0;
        @(negedge clock_in);
        $display("test gen updates done");
    endtask

    task automatic test_gen_offsets();
        gen_op(MODE_REG_OFFSET, 1'b0, KIND_MOVE, 16'h2300, 16'h01FE, 10'h0, 1'b0, 16'h24FE, 1'b0, 16'h0);
        gen_op(MODE_REG_OFFSET, 1'b1, KIND_ACC_DSP, 16'hFFFF, 16'h0003, 10'h0, 1'b0, 16'h0002, 1'b0, 16'h0);
        gen_op(MODE_LIT_OFFSET, 1'b0, KIND_MOVE, 16'h2944, 16'h5555, 10'h300, 1'b0, 16'h2844, 1'b0, 16'h0);
        gen_op(MODE_LIT_OFFSET, 1'b1, KIND_MOVE, 16'hFFF0, 16'h0, 10'h1FF, 1'b0, 16'h01EF, 1'b0, 16'h0);
        gen_op(MODE_REG_OFFSET, 1'b0, KIND_OTHER, 16'h2300, 16'h0002, 10'h0, 1'b1, 16'h0, 1'b0, 16'h0);
        gen_op(MODE_LIT_OFFSET, 1'b0, KIND_ACC_DSP, 16'h2300, 16'h0, 10'h020, 1'b1, 16'h0, 1'b0, 16'h0);
        gen_op(mode_t'(7'h03), 1'b0, KIND_MOVE, 16'h2300, 16'h0, 10'h0, 1'b1, 16'h0, 1'b0, 16'h0);
        gen_req.valid <= 1'b0;
        @(negedge clock_in);
        $display("test gen offsets done");
    endtask

    task automatic test_mac();
        logic [15:0] d;
        sh = '{16'h1000, 16'h1100, 16'h2000, 16'h2100, 16'h0010};
        load <= 1'b1;
        @(negedge clock_in);
        load <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            d = 16'(2 * s);
            mac_op('{MAC_POST_INC, 2'(s), X_POINTER_A_IDX}, '{MAC_POST_DEC, 2'(s), Y_POINTER_B_IDX},
                   '{1'b0, sh.x_pointer_a, 1'b1, X_POINTER_A_IDX, sh.x_pointer_a + d},
                   '{1'b0, sh.y_pointer_b, 1'b1, Y_POINTER_B_IDX, sh.y_pointer_b - d});
            sh.x_pointer_a += d;
            sh.y_pointer_b -= d;
        end
        mac_op('{MAC_REG_OFF, 2'h0, 4'h0}, '{MAC_REG_OFF, 2'h0, 4'h0},
               '{1'b0, sh.x_pointer_b + 16'h0010, 1'b0, 4'h0, 16'h0},
               '{1'b0, sh.y_pointer_b + 16'h0010, 1'b0, 4'h0, 16'h0});
        mac_op('{MAC_NO_MOD, 2'h1, X_POINTER_B_IDX}, '{MAC_NO_MOD, 2'h1, Y_POINTER_A_IDX},
               '{1'b0, sh.x_pointer_b, 1'b0, 4'h0, 16'h0},
               '{1'b0, sh.y_pointer_a, 1'b0, 4'h0, 16'h0});
        mac_op('{MAC_POST_INC, 2'h1, Y_POINTER_A_IDX}, '{MAC_POST_DEC, 2'h1, Y_POINTER_B_IDX},
               '{1'b1, 16'h0, 1'b0, 4'h0, 16'h0},
               '{1'b0, sh.y_pointer_b, 1'b1, Y_POINTER_B_IDX, sh.y_pointer_b - 16'h2});
        mac_op('{MAC_POST_DEC, 2'h1, X_POINTER_B_IDX}, '{MAC_POST_INC, 2'h0, Y_POINTER_A_IDX},
               '{1'b0, sh.x_pointer_b, 1'b1, X_POINTER_B_IDX, sh.x_pointer_b - 16'h2},
               '{1'b1, 16'h0, 1'b0, 4'h0, 16'h0});
        mac_req.valid <= 1'b0;
        @(negedge clock_in);
        $display("test mac done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clock_in);
        test_reset();
        test_gen_updates();
        test_gen_offsets();
        test_mac();
        complete_run();
    end
endmodule
`default_nettype wire
